// >>> rtl/bcp_pkg.sv
// package: register map, field positions, reset values and timing counts
package bcp_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;

	// register byte addresses
	localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;

	// field positions in bus_area_control_primary
	localparam int ADDR_PULLUP_BIT = 15;
	localparam int DATA_PULLUP_BIT = 14;
	localparam int STANDBY_FLOAT_BIT = 13;
	localparam int STROBE_FLOAT_BIT = 12;
	localparam int BYTE_ORDER_BIT = 11;
	localparam int AREA0_BURST_LSB = 9;
	localparam int AREA5_BURST_LSB = 7;
	localparam int AREA6_BURST_LSB = 5;
	localparam int AREA23_TYPE_LSB = 2;
	localparam int AREA5_CARD_BIT = 1;
	localparam int AREA6_CARD_BIT = 0;

	localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;

	// status register layout width
	localparam int STAT_W = 8;

	// address pull-up window after bus acknowledge, in cycles
	localparam logic [2:0] ADDR_PULLUP_CYCLES = 3'h4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bcp_pkg

// >>> rtl/bcp_pin_if.sv
// interface: pin configuration from the register file and pin status back
`timescale 1ns/10ps
`default_nettype none
interface bcp_pin_if;
	import bcp_pkg::*;
	logic addr_pullup_sel;
	logic data_pullup_sel;
	logic standby_high_sel;
	logic strobe_drive_sel;
	logic [STAT_W-1:0] status;
	modport regs (output addr_pullup_sel, output data_pullup_sel, output standby_high_sel,
		output strobe_drive_sel, input status);
	modport pins (input addr_pullup_sel, input data_pullup_sel, input standby_high_sel,
		input strobe_drive_sel, output status);
endinterface : bcp_pin_if
`default_nettype wire

// >>> rtl/bcp_sync.sv
// two-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
`default_nettype none
module bcp_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	// no reset: the chain must keep sampling the strap while reset is held
	always_ff @(posedge clk_i) begin
		meta_q <= d_i;
		q_o <= meta_q;
	end
endmodule : bcp_sync
`default_nettype wire

// >>> rtl/bcp_pin_ctrl.sv
// pin state control: pull-ups, standby float or drive, strobe float or drive
`timescale 1ns/10ps
`default_nettype none
module bcp_pin_ctrl
	import bcp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	bcp_pin_if.pins cfg,
	// synchronised levels
	input wire logic standby_i,
	input wire logic bus_ack_i,
	input wire logic data_busy_i,
	input wire logic manual_rst_i,
	// pin controls
	output logic addr_pullup_o,
	output logic data_pullup_o,
	output logic mem_ctrl_hiz_o,
	output logic mem_ctrl_high_o,
	output logic strobe_hiz_o,
	output logic strobe_drive_o
);
	logic bus_ack_q;
	logic [2:0] pull_cnt_q;
	logic [2:0] pull_cnt_d;
	wire ack_rise = bus_ack_i & ~bus_ack_q;
	wire strobe_idle = standby_i | bus_ack_i;

	always_comb begin
		pull_cnt_d = pull_cnt_q;
		if (manual_rst_i) begin
			pull_cnt_d = 3'h0;
		end else if (ack_rise && cfg.addr_pullup_sel) begin
			pull_cnt_d = ADDR_PULLUP_CYCLES;
		end else if (pull_cnt_q != 3'h0) begin
			pull_cnt_d = pull_cnt_q - 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_ack_q <= 1'b0;
			pull_cnt_q <= 3'h0;
			addr_pullup_o <= 1'b0;
			data_pullup_o <= 1'b0;
			mem_ctrl_hiz_o <= 1'b0;
			mem_ctrl_high_o <= 1'b0;
			strobe_hiz_o <= 1'b0;
			strobe_drive_o <= 1'b0;
		end else begin
			bus_ack_q <= bus_ack_i;
			pull_cnt_q <= pull_cnt_d;
			addr_pullup_o <= pull_cnt_d != 3'h0;
			data_pullup_o <= cfg.data_pullup_sel & ~data_busy_i;
			mem_ctrl_hiz_o <= standby_i & ~cfg.standby_high_sel;
			mem_ctrl_high_o <= standby_i & cfg.standby_high_sel;
			strobe_hiz_o <= strobe_idle & ~cfg.strobe_drive_sel;
			strobe_drive_o <= strobe_idle & cfg.strobe_drive_sel;
		end
	end

	assign cfg.status = {strobe_drive_o, strobe_hiz_o, mem_ctrl_high_o, mem_ctrl_hiz_o,
		data_pullup_o, addr_pullup_o, bus_ack_i, standby_i};
endmodule : bcp_pin_ctrl
`default_nettype wire

// >>> rtl/bcp_top.sv
// bus area control register with axi4-lite access and pin state control
`timescale 1ns/10ps
`default_nettype none
module bcp_top (
	// clock and power-on reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// axi4-lite write address
	input wire logic [bcp_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic [2:0] S_AXI_AWPROT_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	// axi4-lite write data
	input wire logic [bcp_pkg::DATA_W-1:0] S_AXI_WDATA_I,
	input wire logic [bcp_pkg::DATA_W/8-1:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	// axi4-lite write response
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// axi4-lite read address
	input wire logic [bcp_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic [2:0] S_AXI_ARPROT_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	// axi4-lite read data
	output logic [bcp_pkg::DATA_W-1:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// device state pins
	input wire logic STANDBY_I,
	input wire logic BUS_ACK_I,
	input wire logic DATA_BUS_BUSY_I,
	input wire logic MANUAL_RST_I,
	input wire logic BYTE_ORDER_STRAP_PIN_I,
	// pin state controls
	output logic ADDR_PULLUP_O,
	output logic DATA_PULLUP_O,
	output logic MEM_CTRL_HIZ_O,
	output logic MEM_CTRL_HIGH_O,
	output logic STROBE_HIZ_O,
	output logic STROBE_DRIVE_O,
	// area configuration
	output logic LITTLE_ENDIAN_O,
	output logic [1:0] AREA0_BURST_O,
	output logic [1:0] AREA5_BURST_O,
	output logic [1:0] AREA6_BURST_O,
	output logic [2:0] AREA23_MEM_TYPE_O,
	output logic AREA5_CARD_SPACE_O,
	output logic AREA6_CARD_SPACE_O
);
	import bcp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic is_reg(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
		is_reg = addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
	endfunction : is_reg

	// mapped offsets answer okay, every other word a slave error with no effect
	// byte-address bits 1:0 never reach the decode, so any byte of a word hits it
	function automatic logic [1:0] resp_for(input logic hit);
		resp_for = hit ? RESP_OKAY : RESP_SLVERR;
	endfunction : resp_for

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [4:0] pins_s;
	logic standby_s;
	logic bus_ack_s;
	logic data_busy_s;
	logic manual_rst_s;
	logic strap_s;
	logic [4:0] pins_raw;

	// every pin is asynchronous to the core clock; nothing reads it before the second flop
	// the strap keeps flowing through the chain while reset is held, so reset captures it
	assign pins_raw = {BYTE_ORDER_STRAP_PIN_I, MANUAL_RST_I, DATA_BUS_BUSY_I, BUS_ACK_I, STANDBY_I};

	bcp_sync #(.W(5)) u_sync (
		.clk_i(CORE_CLK_I),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	assign standby_s = pins_s[0];
	assign bus_ack_s = pins_s[1];
	assign data_busy_s = pins_s[2];
	assign manual_rst_s = pins_s[3];
	assign strap_s = pins_s[4];

	////////////////////////////////////////////////////////////////////////////
	// write channel

	logic aw_have_q;
	logic w_have_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [DATA_W/8-1:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic awready_q;
	logic wready_q;

	wire aw_take = S_AXI_AWVALID_I & awready_q;
	wire w_take = S_AXI_WVALID_I & wready_q;
	wire b_done = bvalid_q & S_AXI_BREADY_I;
	wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	wire wr_hit_ctrl = is_reg(aw_addr_q, CTRL_OFS);
	wire wr_hit_stat = is_reg(aw_addr_q, STAT_OFS);
	wire wr_hit = wr_hit_ctrl | wr_hit_stat;
	wire [1:0] bresp_d = resp_for(wr_hit);
	wire aw_have_d = (aw_have_q | aw_take) & ~wr_fire;
	wire w_have_d = (w_have_q | w_take) & ~wr_fire;
	wire bvalid_d = (bvalid_q & ~b_done) | wr_fire;

	// address and data are parked independently and the write fires once both are held;
	// the owed response blocks both readies, so a second write cannot overtake it
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			if (aw_take) begin
				aw_addr_q <= S_AXI_AWADDR_I;
			end
			if (w_take) begin
				w_data_q <= S_AXI_WDATA_I;
				w_strb_q <= S_AXI_WSTRB_I;
			end
			bvalid_q <= bvalid_d;
			if (wr_fire) begin
				bresp_q <= bresp_d;
			end
			// one write at a time: no new address or data while a response is owed
			awready_q <= ~aw_have_d & ~bvalid_d;
			wready_q <= ~w_have_d & ~bvalid_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control register

	logic [REG_W-1:0] ctrl_q;
	logic [REG_W-1:0] ctrl_d;
	wire [REG_W-1:0] wr_mask;
	// a write lands in the control register only when it is the word addressed
	wire ctrl_wr = wr_fire & wr_hit_ctrl;

	// one strobe per byte lane of the register; lanes above the register width are ignored
	for (genvar g = 0; g < REG_W/8; g++) begin : g_lane
		assign wr_mask[g*8 +: 8] = {8{w_strb_q[g]}};
	end

	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_wr) begin
			ctrl_d = (ctrl_q & ~wr_mask) | (w_data_q[REG_W-1:0] & wr_mask);
		end
		// the byte-order bit is copied from its own flop, so no write path reaches it
		ctrl_d[BYTE_ORDER_BIT] = ctrl_q[BYTE_ORDER_BIT];
	end

	// only the power-on reset reaches this register; manual reset and standby
	// are plain pins that it never looks at
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			ctrl_q <= CTRL_RESET;
			ctrl_q[BYTE_ORDER_BIT] <= strap_s;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read channel

	logic arready_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic [STAT_W-1:0] pin_status;

	wire ar_take = S_AXI_ARVALID_I & arready_q;
	wire r_done = rvalid_q & S_AXI_RREADY_I;
	wire rd_hit_ctrl = is_reg(S_AXI_ARADDR_I, CTRL_OFS);
	wire rd_hit_stat = is_reg(S_AXI_ARADDR_I, STAT_OFS);
	wire rd_hit = rd_hit_ctrl | rd_hit_stat;
	wire [1:0] rresp_d = resp_for(rd_hit);
	wire [DATA_W-1:0] rd_ctrl_word = {{(DATA_W-REG_W){1'b0}}, ctrl_q};
	wire [DATA_W-1:0] rd_stat_word = {{(DATA_W-STAT_W){1'b0}}, pin_status};

	// the read word is captured with the address, so a later pin change never tears it
	wire [DATA_W-1:0] rd_word = rd_hit_ctrl ? rd_ctrl_word : rd_hit_stat ? rd_stat_word : '0;

	// one read at a time: ready falls with the take and rises again when the data is taken

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rresp_d;
			end else if (r_done) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end else if (!rvalid_q) begin
				arready_q <= 1'b1;
			end
		end
	end

	assign S_AXI_AWREADY_O = awready_q;
	assign S_AXI_WREADY_O = wready_q;
	assign S_AXI_BVALID_O = bvalid_q;
	assign S_AXI_BRESP_O = bresp_q;
	assign S_AXI_ARREADY_O = arready_q;
	assign S_AXI_RVALID_O = rvalid_q;
	assign S_AXI_RDATA_O = rdata_q;
	assign S_AXI_RRESP_O = rresp_q;

	////////////////////////////////////////////////////////////////////////////
	// pin state control

	// four select bits go out to the pin controller, eight status bits come back;
	// the status word is read only, writes to it are answered but change nothing
	bcp_pin_if u_pin_if ();

	assign u_pin_if.addr_pullup_sel = ctrl_q[ADDR_PULLUP_BIT];
	assign u_pin_if.data_pullup_sel = ctrl_q[DATA_PULLUP_BIT];
	assign u_pin_if.standby_high_sel = ctrl_q[STANDBY_FLOAT_BIT];
	assign u_pin_if.strobe_drive_sel = ctrl_q[STROBE_FLOAT_BIT];
	assign pin_status = u_pin_if.status;

	bcp_pin_ctrl u_pin_ctrl (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.cfg(u_pin_if.pins),
		.standby_i(standby_s),
		.bus_ack_i(bus_ack_s),
		.data_busy_i(data_busy_s),
		.manual_rst_i(manual_rst_s),
		.addr_pullup_o(ADDR_PULLUP_O),
		.data_pullup_o(DATA_PULLUP_O),
		.mem_ctrl_hiz_o(MEM_CTRL_HIZ_O),
		.mem_ctrl_high_o(MEM_CTRL_HIGH_O),
		.strobe_hiz_o(STROBE_HIZ_O),
		.strobe_drive_o(STROBE_DRIVE_O)
	);

	////////////////////////////////////////////////////////////////////////////
	// area configuration, straight from the register

	// a flag of one means little-endian for every physical space
	assign LITTLE_ENDIAN_O = ctrl_q[BYTE_ORDER_BIT];
	// burst fields pass on untouched; burst lengths are decided by the cycle engine
	assign AREA0_BURST_O = ctrl_q[AREA0_BURST_LSB +: 2];
	assign AREA5_BURST_O = ctrl_q[AREA5_BURST_LSB +: 2];
	assign AREA6_BURST_O = ctrl_q[AREA6_BURST_LSB +: 2];
	// reserved type codes are stored as written; the cycle engine must not use them
	assign AREA23_MEM_TYPE_O = ctrl_q[AREA23_TYPE_LSB +: 3];
	// a card bit of one selects card-interface cycles for its area
	assign AREA5_CARD_SPACE_O = ctrl_q[AREA5_CARD_BIT];
	assign AREA6_CARD_SPACE_O = ctrl_q[AREA6_CARD_BIT];

	// protection bits and the upper write half carry no meaning for this slave
	wire unused_prot = ^{S_AXI_AWPROT_I, S_AXI_ARPROT_I};
	wire unused_wdata = ^{w_data_q[DATA_W-1:REG_W], w_strb_q[DATA_W/8-1:2]};

endmodule : bcp_top
`default_nettype wire

// >>> tb/bcp_assertions.sv
// checker: handshake and pin timing properties of bcp_top
`timescale 1ns/10ps
`default_nettype none
module bcp_assertions (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic S_AXI_AWVALID_I,
	input wire logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input wire logic S_AXI_WREADY_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_ARVALID_I,
	input wire logic S_AXI_ARREADY_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic STANDBY_I,
	input wire logic BUS_ACK_I,
	input wire logic DATA_BUS_BUSY_I,
	input wire logic ADDR_PULLUP_O,
	input wire logic DATA_PULLUP_O,
	input wire logic MEM_CTRL_HIZ_O,
	input wire logic MEM_CTRL_HIGH_O,
	input wire logic STROBE_HIZ_O,
	input wire logic STROBE_DRIVE_O,
	input wire logic LITTLE_ENDIAN_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_wr; S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O; endsequence
	sequence s_pulse; ADDR_PULLUP_O [*4] ##1 !ADDR_PULLUP_O; endsequence
	property p_wr; s_wr |=> !S_AXI_AWREADY_O ##1 S_AXI_BVALID_O; endproperty
	a_wr: assert property (p_wr) else $error("write answer late");
	property p_bone; S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O; endproperty
	a_bone: assert property (p_bone) else $error("write answer repeated");
	property p_rd; S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O; endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_rup; S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0; endproperty
	a_rup: assert property (p_rup) else $error("upper read half set");
	property p_end; 1'b1 |=> $stable(LITTLE_ENDIAN_O); endproperty
	a_end: assert property (p_end) else $error("byte order moved");
	property p_apu; $rose(ADDR_PULLUP_O) |-> s_pulse; endproperty
	a_apu: assert property (p_apu) else $error("pull-up window length");
	// outputs follow the pins three edges later: two sync flops and one output flop
	property p_mem; (MEM_CTRL_HIZ_O || MEM_CTRL_HIGH_O) == $past(STANDBY_I, 3) && !(MEM_CTRL_HIZ_O && MEM_CTRL_HIGH_O); endproperty
	a_mem: assert property (p_mem) else $error("standby outputs");
	property p_stb; (STROBE_HIZ_O || STROBE_DRIVE_O) == ($past(STANDBY_I, 3) || $past(BUS_ACK_I, 3)); endproperty
	a_stb: assert property (p_stb) else $error("strobe state");
	property p_dpu; DATA_PULLUP_O |-> !$past(DATA_BUS_BUSY_I, 3); endproperty
	a_dpu: assert property (p_dpu) else $error("data pull-up while busy");
endmodule : bcp_assertions
`default_nettype wire

// >>> tb/test_bcp_top.sv
// testbench: register access, reset and pin state scenarios
`timescale 1ns/10ps
`default_nettype none
module test_bcp_top;
	import bcp_pkg::*;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, stby = 0, ack = 0, busy = 0, mrst = 0, strap = 1;
	logic [11:0] awa = '0, ara = '0;
	logic [31:0] wd = '0, rdat, x, v;
	logic [3:0] ws = '0, s;
	logic [1:0] br, rrs, r, a0b, a5b, a6b;
	logic [2:0] amt;
	logic [15:0] m;
	logic awr, wrd, bv, arr, rv, apu, dpu, mhz, mhi, shz, sdr, le, a5c, a6c;
	int error_cnt = 0, samples_checked = 0, cyc = 0, seed = 32'h473c, k, c;
	bcp_top i_bcp_top (.CORE_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWPROT_I(3'h0),
		.S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
		.S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
		.S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(3'h0), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rrs), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rry), .STANDBY_I(stby), .BUS_ACK_I(ack), .DATA_BUS_BUSY_I(busy),
		.MANUAL_RST_I(mrst), .BYTE_ORDER_STRAP_PIN_I(strap), .ADDR_PULLUP_O(apu), .DATA_PULLUP_O(dpu),
		.MEM_CTRL_HIZ_O(mhz), .MEM_CTRL_HIGH_O(mhi), .STROBE_HIZ_O(shz), .STROBE_DRIVE_O(sdr),
		.LITTLE_ENDIAN_O(le), .AREA0_BURST_O(a0b), .AREA5_BURST_O(a5b), .AREA6_BURST_O(a6b),
		.AREA23_MEM_TYPE_O(amt), .AREA5_CARD_SPACE_O(a5c), .AREA6_CARD_SPACE_O(a6c));
	always #2.5 clk = ~clk;
	// the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	task chk(input logic [35:0] g, input logic [35:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task results();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	// lane 1 carries bits 15:8, the strap bit never follows the data
	function logic [15:0] nxt(input logic [15:0] o, input logic [31:0] d, input logic [3:0] st);
		logic [15:0] n;
		n = o;
		if (st[0]) n[7:0] = d[7:0];
		if (st[1]) n[15:8] = d[15:8];
		n[11] = o[11];
		return n;
	endfunction : nxt
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] rs);
		@(posedge clk);
		awa <= a;
		wd <= d;
		ws <= st;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (awv || wv);
		do @(posedge clk); while (!bv);
		rs = br;
		bry <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		d = rdat;
		rs = rrs;
		rry <= 1'b0;
	endtask : rd
	task do_rst(input logic st);
		@(posedge clk);
		strap <= st;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		m = {4'h0, st, 11'h0};
	endtask : do_rst
	initial begin
		do_rst(1'b1);
		rd(CTRL_OFS, v, r);
		chk(v, 32'h800);
		chk(le, 1'b1);
		for (k = 0; k < 12; k++) begin
			x = k ? $random(seed) : '1;
			s = k ? x[7:4] : 4'hf;
			wr(CTRL_OFS, x, s, r);
			m = nxt(m, x, s);
			rd(CTRL_OFS, v, r);
			chk({r, v}, {RESP_OKAY, 16'h0, m});
			chk({a0b, a5b, a6b, amt, a5c, a6c}, m[10:0]);
		end
		wr(12'h008, '1, 4'hf, r);
		chk(r, RESP_SLVERR);
		rd(12'h008, v, r);
		chk({r, v}, {RESP_SLVERR, 32'h0});
		wr(STAT_OFS, '1, 4'hf, r);
		chk(r, RESP_OKAY);
		$display("register tests done");
		for (k = 0; k < 16; k++) begin
			x = k << 12;
			wr(CTRL_OFS, x, 4'h2, r);
			m = nxt(m, x, 4'h2);
			stby <= 1'b1;
			busy <= 1'b0;
			repeat (5) @(posedge clk);
			chk({mhi, mhz, sdr, shz, dpu}, {m[13], !m[13], m[12], !m[12], m[14]});
			rd(STAT_OFS, v, r);
			chk({r, v}, {RESP_OKAY, 24'h0, m[12], !m[12], m[13], !m[13], m[14], 3'b001});
			stby <= 1'b0;
			busy <= 1'b1;
			ack <= 1'b1;
			c = 0;
			repeat (10) begin
				@(posedge clk);
				c += apu;
			end
			chk(c, m[15] ? 4 : 0);
			chk({mhi, mhz, sdr, shz, dpu}, {2'b0, m[12], !m[12], 1'b0});
			ack <= 1'b0;
		end
		$display("pin tests done");
		mrst <= 1'b1;
		stby <= 1'b1;
		repeat (5) @(posedge clk);
		mrst <= 1'b0;
		stby <= 1'b0;
		rd(CTRL_OFS, v, r);
		chk(v, {16'h0, m});
		do_rst(1'b0);
		wr(CTRL_OFS, 32'h800, 4'hf, r);
		rd(CTRL_OFS, v, r);
		chk({le, v}, 0);
		$display("reset tests done");
		results();
	end
endmodule : test_bcp_top
bind bcp_top bcp_assertions i_bcp_assertions (.*);
`default_nettype wire
